// >>> sim/fps_host_model.sv
// Bus-side host model that writes commands, reads bytes and polls for completion.
`timescale 1ns/1ps
module fps_host_model
   import fps_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic [DATA_W-1:0] rd_data,
   output fps_req_t               req
);
   initial begin
      req = '0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req.addr  <= a;
      req.wdata <= d;
      req.wr    <= 1'b1;
      @(posedge sys_clk);
      req.wr    <= 1'b0;
   endtask : wr

   // Read data are registered at the edge that samples the read and hold until the next read; they are taken just after that edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge sys_clk);
      req.addr <= a;
      req.rd   <= 1'b1;
      @(posedge sys_clk);
      req.rd   <= 1'b0;
      #1;
      r = rd_data;
   endtask : rd

   task automatic unlock();
      wr(UNLK_ADDR1, UNLK_DATA1);
      wr(UNLK_ADDR2, UNLK_DATA2);
   endtask : unlock

   task automatic prog(input logic [7:0] a, input logic [7:0] d);
      unlock();
      wr(UNLK_ADDR1, CMD_PROG);
      wr(a, d);
   endtask : prog

   task automatic erase(input logic [7:0] a, input logic [7:0] c);
      unlock();
      wr(UNLK_ADDR1, CMD_ERASE);
      unlock();
      wr(a, c);
   endtask : erase

   // Polls the programmed byte or a byte of the erased sector until two reads agree.
   task automatic poll_done(input logic [7:0] a, output logic ok, output logic [7:0] last);
      logic [7:0] prev;
      logic [7:0] cur;
      ok = 1'b0;
      rd(a, prev);
      for (int i = 0; i < 200 && !ok; i++) begin
         rd(a, cur);
         ok   = (cur === prev);
         prev = cur;
      end
      last = prev;
   endtask : poll_done
endmodule : fps_host_model

// >>> sim/tb.sv
// Self-checking bench for the flash program status-flag block.
`timescale 1ns/1ps
module tb
   import fps_pkg::*;
   ;
   localparam int PROG_T  = 20;
   localparam int ERASE_T = 40;
   localparam int PROT_T  = 30;

   logic              sys_clk;
   logic              rst_b;
   fps_req_t          req;
   logic [N_SECT-1:0] sector_protect;
   logic [DATA_W-1:0] rd_data;
   logic              busy;
   logic              error;
   int                err_count;
   int                num_checks;
   int                cyc;
   int                n;
   logic [7:0]        r1;
   logic [7:0]        r2;
   logic              ok;

   fps_flash_status #(
      .PROG_CYCLES  (PROG_T),
      .ERASE_CYCLES (ERASE_T),
      .PROT_CYCLES  (PROT_T)
   ) i_fps_flash_status (
      .sys_clk        (sys_clk),
      .rst_b          (rst_b),
      .req            (req),
      .sector_protect (sector_protect),
      .rd_data        (rd_data),
      .busy           (busy),
      .error          (error)
   );

   fps_host_model i_fps_host_model (
      .sys_clk (sys_clk),
      .rd_data (rd_data),
      .req     (req)
   );

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t byte %h expected %h", $time, got, exp);
      end
   endtask : chk8

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk1

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic wait_idle(output int cnt);
      cnt = 0;
      while (busy !== 1'b0 && cnt < 500) begin
         @(posedge sys_clk);
         #1;
         cnt++;
      end
   endtask : wait_idle

   // The whole sequence needs well under a thousand cycles.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_count++;
         tally_and_finish();
      end
   end

   initial begin
      rst_b          = 1'b0;
      sector_protect = '0;
      err_count      = 0;
      num_checks     = 0;
      cyc            = 0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      i_fps_host_model.rd(8'h12, r1);
      chk8(r1, ERASED);
      chk1(busy, 1'b0);
      chk1(error, 1'b0);
      // Three pulses must not start status mode, so a read then returns memory.
      i_fps_host_model.unlock();
      i_fps_host_model.wr(UNLK_ADDR1, CMD_PROG);
      i_fps_host_model.rd(8'h12, r1);
      chk8(r1, ERASED);
      chk1(busy, 1'b0);
      i_fps_host_model.wr(8'h12, 8'h5a);
      i_fps_host_model.rd(8'h12, r1);
      i_fps_host_model.rd(8'h12, r2);
      chk1(busy, 1'b1);
      chk8(r1 & 8'hbf, 8'h9f);
      chk8(r1 ^ r2, 8'h40);
      i_fps_host_model.poll_done(8'h12, ok, r1);
      chk1(ok, 1'b1);
      chk8(r1, 8'h5a);
      chk1(busy, 1'b0);
      // Back-to-back program with bit 7 set in the data.
      i_fps_host_model.prog(8'h13, 8'hd5);
      i_fps_host_model.rd(8'h13, r1);
      chk8(r1 & 8'hbf, 8'h1f);
      i_fps_host_model.poll_done(8'h13, ok, r1);
      chk8(r1, 8'hd5);
      // Sector erase of sector 1; five pulses alone still leave reads plain.
      i_fps_host_model.unlock();
      i_fps_host_model.wr(UNLK_ADDR1, CMD_ERASE);
      i_fps_host_model.unlock();
      i_fps_host_model.rd(8'h12, r1);
      chk8(r1, 8'h5a);
      i_fps_host_model.wr(8'h10, CMD_SECT);
      i_fps_host_model.rd(8'h12, r1);
      i_fps_host_model.rd(8'h12, r2);
      chk8(r1 & 8'hbf, 8'h1a);
      chk8(r1 ^ r2, 8'h40);
      i_fps_host_model.poll_done(8'h12, ok, r1);
      chk8(r1, ERASED);
      // Program into a protected sector is dropped.
      @(posedge sys_clk);
      sector_protect <= 12'h004;
      i_fps_host_model.prog(8'h25, 8'h00);
      @(posedge sys_clk);
      #1;
      chk1(busy, 1'b0);
      i_fps_host_model.rd(8'h25, r1);
      chk8(r1, ERASED);
      // Erase of a protected sector only holds the status for a while.
      i_fps_host_model.erase(8'h20, CMD_SECT);
      i_fps_host_model.rd(8'h25, r1);
      chk8(r1 & 8'hc0, 8'h00);
      chk1(busy, 1'b1);
      wait_idle(n);
      chk1((n >= PROT_T - 6) && (n <= PROT_T), 1'b1);
      i_fps_host_model.rd(8'h25, r1);
      chk8(r1, ERASED);
      // A zero turned back into a one fails and sticks until the reset command.
      @(posedge sys_clk);
      sector_protect <= '0;
      i_fps_host_model.prog(8'h30, 8'h00);
      i_fps_host_model.poll_done(8'h30, ok, r1);
      chk8(r1, 8'h00);
      i_fps_host_model.prog(8'h30, 8'h01);
      @(posedge sys_clk);
      #1;
      chk1(error, 1'b1);
      chk1(busy, 1'b1);
      i_fps_host_model.rd(8'h30, r1);
      chk8(r1 & 8'h20, 8'h20);
      // Later work keeps clear of the failed sector; this program is ignored while failed.
      i_fps_host_model.prog(8'h41, 8'h00);
      chk1(error, 1'b1);
      i_fps_host_model.wr(UNLK_ADDR1, CMD_RESET);
      @(posedge sys_clk);
      #1;
      chk1(error, 1'b0);
      chk1(busy, 1'b0);
      i_fps_host_model.rd(8'h30, r1);
      chk8(r1, 8'h00);
      i_fps_host_model.prog(8'h41, 8'h3c);
      i_fps_host_model.poll_done(8'h41, ok, r1);
      chk8(r1, 8'h3c);
      // Bulk erase clears all twelve sectors, addresses 0x00 to 0xbf; the bytes above them are left alone.
      i_fps_host_model.erase(UNLK_ADDR1, CMD_BULK);
      i_fps_host_model.poll_done(8'h41, ok, r1);
      chk8(r1, ERASED);
      chk1(error, 1'b0);
      tally_and_finish();
   end
endmodule : tb

// >>> src/fps_flash_status.sv
// Flash command sequencer with data polling, toggle and error status flags.
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module fps_flash_status
   import fps_pkg::*;
#(
   parameter int PROG_CYCLES  = PROG_CYC,
   parameter int ERASE_CYCLES = ERASE_CYC,
   parameter int PROT_CYCLES  = PROT_CYC
) (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire fps_req_t          req,
   input  wire logic [N_SECT-1:0] sector_protect,
   output logic      [DATA_W-1:0] rd_data,
   output logic                   busy,
   output logic                   error
);

   fps_state_t          state_q, state_d;
   logic [CNT_W-1:0]    cnt_q, cnt_d;
   logic                err_q, err_d;
   logic                tog_q, tog_d;
   logic [ADDR_W-1:0]   tgt_addr_q, tgt_addr_d;
   logic [DATA_W-1:0]   tgt_data_q, tgt_data_d;
   logic [N_SECT-1:0]   ers_mask_q, ers_mask_d;
   logic [DATA_W-1:0]   rd_data_q, rd_data_d;
   logic [DATA_W-1:0]   mem_q [MEM_DEPTH];
   logic [DATA_W-1:0]   mem_rd;
   logic [N_SECT-1:0]   sel;
   logic                prog_blocked;
   logic                zero_to_one;
   logic                status_mode;
   logic                prog_done;
   logic                erase_done;

   // One-hot select of the main and boot sectors for an address; none above the last sector.
   function automatic logic [N_SECT-1:0] sect_sel(input logic [ADDR_W-1:0] a);
      logic [N_SECT-1:0] s;
      s = '0;
      for (int i = 0; i < N_SECT; i++) begin
         if (int'(a >> SECT_SHIFT) == i) begin
            s[i] = 1'b1;
         end
      end
      return s;
   endfunction : sect_sel

   assign sel          = sect_sel(req.addr);
   assign mem_rd       = mem_q[req.addr];
   assign prog_blocked = (sel == '0) || ((sel & sector_protect) != '0);
   assign zero_to_one  = ((~mem_rd) & req.wdata) != '0;
   assign status_mode  = (state_q == S_BPROG) || (state_q == S_BERS) || (state_q == S_FAIL);
   assign prog_done    = (state_q == S_BPROG) && (cnt_q == '0);
   assign erase_done   = (state_q == S_BERS) && (cnt_q == '0);
   assign rd_data      = rd_data_q;
   assign busy         = status_mode || (state_q == S_PNOP);
   assign error        = err_q;

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      err_d      = err_q;
      tgt_addr_d = tgt_addr_q;
      tgt_data_d = tgt_data_q;
      ers_mask_d = ers_mask_q;
      case (state_q)
         S_IDLE: begin
            if (req.wr && req.addr == UNLK_ADDR1 && req.wdata == UNLK_DATA1) begin
               state_d = S_UNLK1;
            end else if (req.wr && req.wdata == CMD_RESET) begin
               err_d = 1'b0;
            end
         end
         S_UNLK1: begin
            if (req.wr) begin
               state_d = (req.addr == UNLK_ADDR2 && req.wdata == UNLK_DATA2) ? S_UNLK2 : S_IDLE;
            end
         end
         S_UNLK2: begin
            if (req.wr) begin
               if (req.addr == UNLK_ADDR1 && req.wdata == CMD_PROG) begin
                  state_d = S_PDATA;
               end else if (req.addr == UNLK_ADDR1 && req.wdata == CMD_ERASE) begin
                  state_d = S_ERS1;
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         S_PDATA: begin
            // The fourth pulse starts the internal cycle, so flags only appear after it.
            if (req.wr) begin
               tgt_addr_d = req.addr;
               tgt_data_d = req.wdata;
               if (prog_blocked) begin
                  state_d = S_IDLE;
               end else if (zero_to_one) begin
                  state_d = S_FAIL;
                  err_d   = 1'b1;
               end else begin
                  state_d = S_BPROG;
                  cnt_d   = CNT_W'(PROG_CYCLES - 1);
               end
            end
         end
         S_ERS1: begin
            if (req.wr) begin
               state_d = (req.addr == UNLK_ADDR1 && req.wdata == UNLK_DATA1) ? S_ERS2 : S_IDLE;
            end
         end
         S_ERS2: begin
            if (req.wr) begin
               state_d = (req.addr == UNLK_ADDR2 && req.wdata == UNLK_DATA2) ? S_ERS3 : S_IDLE;
            end
         end
         S_ERS3: begin
            if (req.wr) begin
               if (req.wdata == CMD_SECT || req.wdata == CMD_BULK) begin
                  ers_mask_d = ((req.wdata == CMD_BULK) ? '1 : sel) & ~sector_protect;
                  tgt_addr_d = req.addr;
                  tgt_data_d = ERASED;
                  if ((((req.wdata == CMD_BULK) ? '1 : sel) & ~sector_protect) == '0) begin
                     state_d = S_PNOP;
                     cnt_d   = CNT_W'(PROT_CYCLES - 1);
                  end else begin
                     state_d = S_BERS;
                     cnt_d   = CNT_W'(ERASE_CYCLES - 1);
                  end
               end else begin
                  state_d = S_IDLE;
               end
            end
         end
         S_BPROG, S_BERS, S_PNOP: begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == '0) begin
               state_d = S_IDLE;
               cnt_d   = '0;
            end
         end
         S_FAIL: begin
            // Failed program keeps reporting status until software issues the reset command.
            if (req.wr && req.wdata == CMD_RESET) begin
               state_d = S_IDLE;
               err_d   = 1'b0;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   always_comb begin
      rd_data_d = rd_data_q;
      tog_d     = tog_q;
      if (req.rd) begin
         if (status_mode) begin
            rd_data_d                 = mem_rd;
            rd_data_d[POLL_BIT]       = (state_q == S_BERS) ? 1'b0
                                                            : ~tgt_data_q[POLL_BIT];
            rd_data_d[TOGGLE_BIT]     = tog_q;
            rd_data_d[ERR_BIT]        = err_q;
            if (sel != '0) begin
               tog_d = ~tog_q;
            end
         end else if (state_q == S_PNOP) begin
            rd_data_d                 = mem_rd;
            rd_data_d[POLL_BIT]       = 1'b0;
            rd_data_d[TOGGLE_BIT]     = 1'b0;
            rd_data_d[ERR_BIT]        = err_q;
         end else begin
            rd_data_d = mem_rd;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         state_q    <= S_IDLE;
         cnt_q      <= '0;
         err_q      <= 1'b0;
         tog_q      <= 1'b0;
         tgt_addr_q <= '0;
         tgt_data_q <= '0;
         ers_mask_q <= '0;
         rd_data_q  <= '0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         err_q      <= err_d;
         tog_q      <= tog_d;
         tgt_addr_q <= tgt_addr_d;
         tgt_data_q <= tgt_data_d;
         ers_mask_q <= ers_mask_d;
         rd_data_q  <= rd_data_d;
      end
   end

   // The array stands in for the cells; reset fills it erased so a bench starts from known data.
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_q[i] <= ERASED;
         end
      end else if (prog_done) begin
         mem_q[tgt_addr_q] <= tgt_data_q;
      end else if (erase_done) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            if ((sect_sel(ADDR_W'(i)) & ers_mask_q) != '0) begin
               mem_q[i] <= ERASED;
            end
         end
      end
   end

   // Helper state that only the checks below read.
   logic              tog_rd_q;
   logic              tog_seen_q;
   logic              last_b6_q;
   logic [CNT_W-1:0]  nop_len_q;

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         tog_rd_q   <= 1'b0;
         tog_seen_q <= 1'b0;
         last_b6_q  <= 1'b0;
         nop_len_q  <= '0;
      end else begin
         tog_rd_q <= req.rd && (state_q == S_BPROG || state_q == S_BERS) && (sel != '0);
         if (!(state_q == S_BPROG || state_q == S_BERS)) begin
            tog_seen_q <= 1'b0;
         end else if (tog_rd_q) begin
            tog_seen_q <= 1'b1;
         end
         if (tog_rd_q) begin
            last_b6_q <= rd_data_q[TOGGLE_BIT];
         end
         nop_len_q <= (state_q == S_PNOP) ? nop_len_q + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   prog_poll_inv_a: assert property ((state_q == S_BPROG) && req.rd |=>
      rd_data_q[POLL_BIT] == !$past(tgt_data_q[POLL_BIT]))
      else $error("Poll bit is not inverted during program.");
   idle_read_true_a: assert property ((state_q == S_IDLE) && req.rd && !req.wr |=>
      rd_data_q == $past(mem_rd))
      else $error("Idle read does not return memory.");
   cmd_busy_start_a: assert property ((state_q == S_PDATA) && req.wr && !prog_blocked
      |=> busy && (state_q == S_BPROG || state_q == S_FAIL))
      else $error("Program pulse did not start the cycle.");
   erase_poll_low_a: assert property ((state_q == S_BERS) && req.rd |=>
      !rd_data_q[POLL_BIT])
      else $error("Poll bit not low during erase.");
   prot_prog_skip_a: assert property ((state_q == S_PDATA) && req.wr && prog_blocked
      |=> (state_q == S_IDLE) && !busy ##1 $stable(mem_q[tgt_addr_q]))
      else $error("Protected program was not ignored.");
   prot_nop_len_a: assert property ($fell(state_q == S_PNOP) |->
      nop_len_q == CNT_W'(PROT_CYCLES))
      else $error("Protected erase hold has wrong length.");
   prot_nop_flags_a: assert property ((state_q == S_PNOP) && req.rd |=>
      rd_data_q[POLL_BIT:TOGGLE_BIT] == 2'b00)
      else $error("Flags not low during protected erase.");
   toggle_flip_a: assert property (tog_rd_q && tog_seen_q |->
      rd_data_q[TOGGLE_BIT] != last_b6_q)
      else $error("Toggle bit did not change between reads.");
   err_normal_a: assert property ((state_q == S_BPROG) || (state_q == S_BERS) |->
      !err_q)
      else $error("Error bit set in a normal cycle.");
   err_set_a: assert property ((state_q == S_PDATA) && req.wr && !prog_blocked && zero_to_one
      |=> err_q && (state_q == S_FAIL))
      else $error("Zero to one program not flagged.");
   err_hold_a: assert property (err_q && !(req.wr && req.wdata == CMD_RESET) |=>
      err_q)
      else $error("Error bit cleared without reset command.");
   pre_cmd_plain_a: assert property (
      (state_q == S_PDATA || state_q == S_ERS3) && req.rd |=> rd_data_q == $past(mem_rd))
      else $error("Status shown before the last command pulse.");
   cycle_end_free_a: assert property (
      prog_done || erase_done |=> !busy && (state_q == S_IDLE))
      else $error("Busy state outlived the internal cycle.");

endmodule : fps_flash_status

// >>> src/fps_pkg.sv
// Package of constants and types for the flash program status-flag block.
package fps_pkg;
   localparam int CLK_MHZ       = 100;
   localparam int PROG_TIME_US  = 10;
   localparam int ERASE_TIME_US = 1000;
   localparam int PROT_NOP_US   = 100;
   localparam int PROG_CYC      = PROG_TIME_US * CLK_MHZ;
   localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
   localparam int PROT_CYC      = PROT_NOP_US * CLK_MHZ;
   localparam int CNT_W         = 20;

   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;
   localparam int MEM_DEPTH  = 256;
   localparam int SECT_SHIFT = 4;
   localparam int N_MAIN     = 8;
   localparam int N_BOOT     = 4;
   localparam int N_SECT     = N_MAIN + N_BOOT;

   localparam int POLL_BIT   = 7;
   localparam int TOGGLE_BIT = 6;
   localparam int ERR_BIT    = 5;

   localparam logic [7:0] UNLK_ADDR1 = 8'h55;
   localparam logic [7:0] UNLK_ADDR2 = 8'haa;
   localparam logic [7:0] UNLK_DATA1 = 8'haa;
   localparam logic [7:0] UNLK_DATA2 = 8'h55;
   localparam logic [7:0] CMD_PROG   = 8'ha0;
   localparam logic [7:0] CMD_ERASE  = 8'h80;
   localparam logic [7:0] CMD_SECT   = 8'h30;
   localparam logic [7:0] CMD_BULK   = 8'h10;
   localparam logic [7:0] CMD_RESET  = 8'hf0;
   localparam logic [7:0] ERASED     = 8'hff;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } fps_req_t;

   typedef enum logic [10:0] {
      S_IDLE  = 11'h001,
      S_UNLK1 = 11'h002,
      S_UNLK2 = 11'h004,
      S_PDATA = 11'h008,
      S_ERS1  = 11'h010,
      S_ERS2  = 11'h020,
      S_ERS3  = 11'h040,
      S_BPROG = 11'h080,
      S_BERS  = 11'h100,
      S_PNOP  = 11'h200,
      S_FAIL  = 11'h400
   } fps_state_t;
endpackage : fps_pkg
